/* File: hfpa_pkg.sv */
// constants of the host fifo port access block: offsets, fields, reset values
package hfpa_pkg;
  // data port alias windows (byte addresses, 32 bytes each)
  localparam logic [7:0] RXD_BASE = 8'h00;
  localparam logic [7:0] TXD_BASE = 8'h20;
  // status queue ports
  localparam logic [7:0] RXS_POP = 8'h40;
  localparam logic [7:0] RXS_LOOK = 8'h44;
  localparam logic [7:0] TXS_POP = 8'h48;
  localparam logic [7:0] TXS_LOOK = 8'h4C;
  // control and status registers
  localparam logic [7:0] CTRL_OFS = 8'hC0;
  localparam logic [7:0] STAT_OFS = 8'hC4;
  localparam logic [7:0] EVT_OFS = 8'hC8;
  localparam logic [7:0] TXLIM_OFS = 8'hCC;
  // level width for 16-deep queues
  localparam int LVL_W = 5;
  // control field positions
  localparam int CTRL_SRST_BIT = 0;
  localparam int CTRL_WMODE_BIT = 1;
  localparam int CTRL_RXD_LIM_LSB = 8;
  localparam int CTRL_RXS_LIM_LSB = 16;
  // status field positions
  localparam int STAT_RXD_LSB = 0;
  localparam int STAT_TXD_LSB = 8;
  localparam int STAT_RXS_LSB = 16;
  localparam int STAT_TXS_LSB = 24;
  // event field positions
  localparam int EVT_TXOVF_BIT = 0;
  localparam int EVT_RXUNF_BIT = 1;
  localparam int EVT_STSEMPTY_BIT = 2;
  localparam int EVT_LINK_LL_BIT = 3;
  localparam int EVT_ERR_LH_BIT = 4;
  // reset values
  localparam logic [LVL_W-1:0] LIM_RST = 5'h10;
  localparam logic WMODE_RST = 1'b0;
endpackage : hfpa_pkg

/* File: hfpa_fifo.sv */
// flip-flop fifo with valid/ready on both sides and a fill level
`timescale 1ns/100ps
module hfpa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH-1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [LW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != FULL);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign level_o = cnt_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : hfpa_fifo

/* File: hfpa_top.sv */
// host access layer: four queues, aliased data ports and attribute registers
// Behaviour
// - writes to read-only registers and ports are ignored, contents unchanged
// - reads of write-only registers and ports return zero
// - write-one-to-clear bits clear on a written one, zero has no effect
// - read-to-clear bits clear when the host reads them
// - latching low and high bits hold until the register is read
// - soft-reset-immune fields keep their value through a software reset
// - reserved address reads may return any value
// - every reset loads configuration registers with their defaults, except word mode on a software reset
// - four queues; data and receive status capacities set by control registers
// - receive status and data queues are read-only to the host
// - receive status pop port returns oldest entry and removes it
// - receive status look port returns oldest entry, queue unchanged
// - every receive data read consumes the word returned; in word mode only the upper half read pops
// - receive data answers at eight dword offsets 00h-1Ch, sixteen in word mode
// - all receive data aliases behave identically
// - transmit status pop port returns oldest entry and removes it
// - transmit status look port returns oldest entry, queue unchanged
// - transmit data is write-only at offsets 20h-3Ch, sixteen words in word mode
// - writes at any transmit data alias push into the one queue
`timescale 1ns/100ps
module hfpa_top #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // host bus, one-cycle strobes
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_rdata_oe_o,
  // receive data from the mac side
  input wire logic rxd_in_valid_i,
  output logic rxd_in_ready_o,
  input wire logic [31:0] rxd_in_data_i,
  // receive status from the mac side
  input wire logic rxs_in_valid_i,
  output logic rxs_in_ready_o,
  input wire logic [31:0] rxs_in_data_i,
  // transmit data to the mac side
  output logic txd_out_valid_o,
  input wire logic txd_out_ready_i,
  output logic [31:0] txd_out_data_o,
  // transmit status from the mac side
  input wire logic txs_in_valid_i,
  output logic txs_in_ready_o,
  input wire logic [31:0] txs_in_data_i,
  // line condition inputs
  input wire logic link_up_i,
  input wire logic line_err_i,
  // mode
  output logic word_mode_o
);
  localparam int LW = hfpa_pkg::LVL_W;

  logic rst_s1_r;
  logic rst_n;
  logic srst_r;
  logic wmode_r;
  logic [LW-1:0] rxd_lim_r;
  logic [LW-1:0] rxs_lim_r;
  logic [LW-1:0] txd_lim_r;
  logic ev_txovf_r;
  logic ev_rxunf_r;
  logic ev_stsempty_r;
  logic link_ll_r;
  logic err_lh_r;
  logic half_rd_r;
  logic half_wr_r;
  logic [15:0] tx_lo_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic rvalid_r;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // address decode; bits 4:0 pick the alias and are ignored on purpose
  logic rx_alias;
  logic tx_alias;
  logic rd_ctrl;
  logic rd_evt;
  logic wr_ctrl;
  logic wr_evt;
  logic wr_txlim;
  assign rx_alias = (bus_addr_i[7:5] == hfpa_pkg::RXD_BASE[7:5]);
  assign tx_alias = (bus_addr_i[7:5] == hfpa_pkg::TXD_BASE[7:5]);
  assign rd_ctrl = bus_rd_i && (bus_addr_i == hfpa_pkg::CTRL_OFS);
  assign rd_evt = bus_rd_i && (bus_addr_i == hfpa_pkg::EVT_OFS);
  assign wr_ctrl = bus_wr_i && (bus_addr_i == hfpa_pkg::CTRL_OFS);
  assign wr_evt = bus_wr_i && (bus_addr_i == hfpa_pkg::EVT_OFS);
  assign wr_txlim = bus_wr_i && (bus_addr_i == hfpa_pkg::TXLIM_OFS);

  // queues
  logic rxd_valid;
  logic rxd_pop;
  logic [31:0] rxd_head;
  logic [LW-1:0] rxd_lvl;
  logic rxd_fifo_ready;
  logic rxs_valid;
  logic rxs_pop;
  logic [31:0] rxs_head;
  logic [LW-1:0] rxs_lvl;
  logic rxs_fifo_ready;
  logic txs_valid;
  logic txs_pop;
  logic [31:0] txs_head;
  logic [LW-1:0] txs_lvl;
  logic txd_push;
  logic txd_below;
  logic txd_fifo_ready;
  logic [31:0] txd_word;
  logic [LW-1:0] txd_lvl;

  // capacity limits only throttle the filling side; storage stays fixed
  assign rxd_in_ready_o = rxd_fifo_ready && (rxd_lvl < rxd_lim_r);
  assign rxs_in_ready_o = rxs_fifo_ready && (rxs_lvl < rxs_lim_r);
  assign txd_below = txd_lvl < txd_lim_r;

  // a read at any alias pops; in word mode the upper half read pops
  assign rxd_pop = bus_rd_i && rx_alias && rxd_valid && (!wmode_r || half_rd_r);
  assign rxs_pop = bus_rd_i && (bus_addr_i == hfpa_pkg::RXS_POP);
  assign txs_pop = bus_rd_i && (bus_addr_i == hfpa_pkg::TXS_POP);
  assign txd_push = bus_wr_i && tx_alias && (!wmode_r || half_wr_r);
  assign txd_word = wmode_r ? {bus_wdata_i[15:0], tx_lo_r} : bus_wdata_i;

  hfpa_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxd (
    .clk_i(clk_i), .rst_n_i(rst_n), .flush_i(srst_r),
    .in_valid_i(rxd_in_valid_i && rxd_in_ready_o), .in_ready_o(rxd_fifo_ready),
    .in_data_i(rxd_in_data_i),
    .out_valid_o(rxd_valid), .out_ready_i(rxd_pop), .out_data_o(rxd_head),
    .level_o(rxd_lvl)
  );
  hfpa_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxs (
    .clk_i(clk_i), .rst_n_i(rst_n), .flush_i(srst_r),
    .in_valid_i(rxs_in_valid_i && rxs_in_ready_o), .in_ready_o(rxs_fifo_ready),
    .in_data_i(rxs_in_data_i),
    .out_valid_o(rxs_valid), .out_ready_i(rxs_pop), .out_data_o(rxs_head),
    .level_o(rxs_lvl)
  );
  hfpa_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txs (
    .clk_i(clk_i), .rst_n_i(rst_n), .flush_i(srst_r),
    .in_valid_i(txs_in_valid_i), .in_ready_o(txs_in_ready_o),
    .in_data_i(txs_in_data_i),
    .out_valid_o(txs_valid), .out_ready_i(txs_pop), .out_data_o(txs_head),
    .level_o(txs_lvl)
  );
  hfpa_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txd (
    .clk_i(clk_i), .rst_n_i(rst_n), .flush_i(srst_r),
    .in_valid_i(txd_push && txd_below), .in_ready_o(txd_fifo_ready),
    .in_data_i(txd_word),
    .out_valid_o(txd_out_valid_o), .out_ready_i(txd_out_ready_i),
    .out_data_o(txd_out_data_o),
    .level_o(txd_lvl)
  );

  // word mode half tracking
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      half_rd_r <= 1'b0;
      half_wr_r <= 1'b0;
      tx_lo_r <= 16'h0000;
    end else if (srst_r || !wmode_r) begin
      half_rd_r <= 1'b0;
      half_wr_r <= 1'b0;
    end else begin
      if (bus_rd_i && rx_alias && rxd_valid) begin
        half_rd_r <= !half_rd_r;
      end
      if (bus_wr_i && tx_alias) begin
        half_wr_r <= !half_wr_r;
        if (!half_wr_r) begin
          tx_lo_r <= bus_wdata_i[15:0];
        end
      end
    end
  end

  // self-clearing soft reset strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= wr_ctrl && bus_wdata_i[hfpa_pkg::CTRL_SRST_BIT] && !srst_r;
    end
  end

  // bus width survives a software reset; only the hard reset loads its default
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wmode_r <= hfpa_pkg::WMODE_RST;
    end else if (wr_ctrl) begin
      wmode_r <= bus_wdata_i[hfpa_pkg::CTRL_WMODE_BIT];
    end
  end

  // capacity configuration
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rxd_lim_r <= hfpa_pkg::LIM_RST;
      rxs_lim_r <= hfpa_pkg::LIM_RST;
      txd_lim_r <= hfpa_pkg::LIM_RST;
    end else if (srst_r) begin
      rxd_lim_r <= hfpa_pkg::LIM_RST;
      rxs_lim_r <= hfpa_pkg::LIM_RST;
      txd_lim_r <= hfpa_pkg::LIM_RST;
    end else begin
      if (wr_ctrl) begin
        rxd_lim_r <= bus_wdata_i[hfpa_pkg::CTRL_RXD_LIM_LSB +: LW];
        rxs_lim_r <= bus_wdata_i[hfpa_pkg::CTRL_RXS_LIM_LSB +: LW];
      end
      if (wr_txlim) begin
        txd_lim_r <= bus_wdata_i[LW-1:0];
      end
    end
  end

  // events: hardware set wins over a clear in the same cycle
  logic set_txovf;
  logic set_rxunf;
  logic set_stsempty;
  assign set_txovf = txd_push && !(txd_fifo_ready && txd_below);
  assign set_rxunf = bus_rd_i && rx_alias && !rxd_valid;
  assign set_stsempty = (rxs_pop && !rxs_valid) || (txs_pop && !txs_valid);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_txovf_r <= 1'b0;
      ev_rxunf_r <= 1'b0;
    end else if (srst_r) begin
      ev_txovf_r <= 1'b0;
      ev_rxunf_r <= 1'b0;
    end else begin
      ev_txovf_r <= set_txovf
        || (ev_txovf_r && !(wr_evt && bus_wdata_i[hfpa_pkg::EVT_TXOVF_BIT]));
      ev_rxunf_r <= set_rxunf
        || (ev_rxunf_r && !(wr_evt && bus_wdata_i[hfpa_pkg::EVT_RXUNF_BIT]));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_stsempty_r <= 1'b0;
    end else if (srst_r) begin
      ev_stsempty_r <= 1'b0;
    end else begin
      ev_stsempty_r <= set_stsempty || (ev_stsempty_r && !rd_evt);
    end
  end

  // latches reload from the live line level when the register is read
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_ll_r <= 1'b1;
      err_lh_r <= 1'b0;
    end else if (rd_evt || srst_r) begin
      link_ll_r <= link_up_i;
      err_lh_r <= line_err_i;
    end else begin
      link_ll_r <= link_ll_r && link_up_i;
      err_lh_r <= err_lh_r || line_err_i;
    end
  end

  // read mux; status, receive data ports and reserved reads have no write path
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rx_alias) begin
      if (!wmode_r) begin
        rdata_nxt = rxd_head;
      end else begin
        rdata_nxt = {16'h0000, half_rd_r ? rxd_head[31:16] : rxd_head[15:0]};
      end
    end else if (tx_alias) begin
      rdata_nxt = 32'h0000_0000;
    end else begin
      unique case (bus_addr_i)
        hfpa_pkg::RXS_POP, hfpa_pkg::RXS_LOOK: rdata_nxt = rxs_head;
        hfpa_pkg::TXS_POP, hfpa_pkg::TXS_LOOK: rdata_nxt = txs_head;
        hfpa_pkg::CTRL_OFS: begin
          rdata_nxt[hfpa_pkg::CTRL_WMODE_BIT] = wmode_r;
          rdata_nxt[hfpa_pkg::CTRL_RXD_LIM_LSB +: LW] = rxd_lim_r;
          rdata_nxt[hfpa_pkg::CTRL_RXS_LIM_LSB +: LW] = rxs_lim_r;
        end
        hfpa_pkg::STAT_OFS: begin
          rdata_nxt[hfpa_pkg::STAT_RXD_LSB +: LW] = rxd_lvl;
          rdata_nxt[hfpa_pkg::STAT_TXD_LSB +: LW] = txd_lvl;
          rdata_nxt[hfpa_pkg::STAT_RXS_LSB +: LW] = rxs_lvl;
          rdata_nxt[hfpa_pkg::STAT_TXS_LSB +: LW] = txs_lvl;
        end
        hfpa_pkg::EVT_OFS: begin
          rdata_nxt[hfpa_pkg::EVT_TXOVF_BIT] = ev_txovf_r;
          rdata_nxt[hfpa_pkg::EVT_RXUNF_BIT] = ev_rxunf_r;
          rdata_nxt[hfpa_pkg::EVT_STSEMPTY_BIT] = ev_stsempty_r;
          rdata_nxt[hfpa_pkg::EVT_LINK_LL_BIT] = link_ll_r;
          rdata_nxt[hfpa_pkg::EVT_ERR_LH_BIT] = err_lh_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= bus_rd_i;
      if (bus_rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign bus_rdata_o = rdata_r;
  assign bus_rdata_oe_o = rvalid_r;
  assign word_mode_o = wmode_r;

  // checks
  property p_ro_rx();
    @(posedge clk_i) disable iff (!rst_n)
    (bus_wr_i && !bus_rd_i && rx_alias && !srst_r && !rxd_in_valid_i) |=> (rxd_lvl == $past(rxd_lvl));
  endproperty
  a_ro_rx: assert property (p_ro_rx) else $error("write changed receive data queue");

  property p_wo_zero();
    @(posedge clk_i) disable iff (!rst_n)
    (bus_rd_i && (tx_alias || bus_addr_i == hfpa_pkg::TXLIM_OFS)) |=> (bus_rdata_o == 32'h0);
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only read not zero");

  property p_w1c();
    @(posedge clk_i) disable iff (!rst_n)
    (wr_evt && bus_wdata_i[hfpa_pkg::EVT_TXOVF_BIT] && !set_txovf) |=> !ev_txovf_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_rc();
    @(posedge clk_i) disable iff (!rst_n)
    (rd_evt && ev_stsempty_r && !set_stsempty) |=>
      !ev_stsempty_r && bus_rdata_o[hfpa_pkg::EVT_STSEMPTY_BIT];
  endproperty
  a_rc: assert property (p_rc) else $error("read did not clear");

  property p_ll_hold();
    @(posedge clk_i) disable iff (!rst_n)
    (!link_ll_r && !rd_evt && !srst_r) |=> !link_ll_r;
  endproperty
  a_ll_hold: assert property (p_ll_hold) else $error("low latch released early");

  property p_soft_reset_immune();
    @(posedge clk_i) disable iff (!rst_n)
    (srst_r && !wr_ctrl) |=> $stable(wmode_r);
  endproperty
  a_soft_reset_immune: assert property (p_soft_reset_immune) else $error("immune field lost on soft reset");

  property p_srst_def();
    @(posedge clk_i) disable iff (!rst_n)
    srst_r |=> (rxd_lim_r == hfpa_pkg::LIM_RST && txd_lim_r == hfpa_pkg::LIM_RST && rxd_lvl == '0);
  endproperty
  a_srst_def: assert property (p_srst_def) else $error("soft reset left non-default");

  property p_rxs_pop();
    @(posedge clk_i) disable iff (!rst_n)
    (rxs_pop && rxs_valid && !srst_r && !rxs_in_valid_i) |=>
      (bus_rdata_o == $past(rxs_head)) && (rxs_lvl == $past(rxs_lvl) - 1'b1);
  endproperty
  a_rxs_pop: assert property (p_rxs_pop) else $error("status pop wrong");

  property p_look();
    @(posedge clk_i) disable iff (!rst_n)
    (bus_rd_i && bus_addr_i == hfpa_pkg::RXS_LOOK && !srst_r && !rxs_in_valid_i) |=>
      (rxs_lvl == $past(rxs_lvl)) && (bus_rdata_o == $past(rxs_head));
  endproperty
  a_look: assert property (p_look) else $error("look port changed queue");

  property p_rx_alias();
    @(posedge clk_i) disable iff (!rst_n)
    (bus_rd_i && rx_alias && rxd_valid && !wmode_r && !srst_r && !rxd_in_valid_i) |=>
      (rxd_lvl == $past(rxd_lvl) - 1'b1);
  endproperty
  a_rx_alias: assert property (p_rx_alias) else $error("alias read did not pop");

  property p_tx_alias();
    @(posedge clk_i) disable iff (!rst_n)
    (txd_push && txd_fifo_ready && txd_below && !srst_r && !txd_out_valid_o) |=>
      (txd_lvl == 5'h01) && (txd_out_data_o == $past(txd_word));
  endproperty
  a_tx_alias: assert property (p_tx_alias) else $error("alias write did not push");

  property p_sc();
    @(posedge clk_i) disable iff (!rst_n)
    srst_r |=> !srst_r;
  endproperty
  a_sc: assert property (p_sc) else $error("self-clearing bit stuck");
endmodule : hfpa_top

/* File: hfpa_mac_model.sv */
// mac side model: fills receive and status queues, drains transmit data
`timescale 1ns/100ps
module hfpa_mac_model (
  // clock and stall control
  input wire logic clk_i,
  input wire logic stall_i,
  // pushes: bit 0 rx data, 1 rx status, 2 tx status
  output logic [2:0] vld_o,
  input wire logic [2:0] rdy_i,
  output logic [31:0] dat_o,
  // transmit data drain
  input wire logic tx_vld_i,
  output logic tx_rdy_o,
  input wire logic [31:0] tx_dat_i
);
  logic [31:0] txq[$];
  initial begin
    vld_o = 3'h0;
    dat_o = 32'h0;
  end
  assign tx_rdy_o = !stall_i;
  always @(posedge clk_i) begin
    if (tx_vld_i && tx_rdy_o) begin
      txq.push_back(tx_dat_i);
    end
  end
  // idle data lines carry the inverse so a stale value never looks valid
  task automatic push(input int q, input logic [31:0] d, output bit ok);
    int n;
    @(posedge clk_i);
    vld_o[q] <= 1'b1;
    dat_o <= d;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      ok = rdy_i[q];
    end
    vld_o[q] <= 1'b0;
    dat_o <= ~d;
  endtask : push
endmodule : hfpa_mac_model

/* File: hfpa_tb_top.sv */
// self-checking bench of the host fifo port access block
`timescale 1ns/100ps
module hfpa_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic oe;
  logic link = 1'b1;
  logic err = 1'b0;
  logic stall = 1'b0;
  logic [2:0] vld;
  logic [2:0] rdy;
  logic [31:0] dat;
  logic tvld;
  logic trdy;
  logic [31:0] tdat;
  logic wmode;
  int fails = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  hfpa_top #(.DEPTH(16)) hfpa_top_inst (
    .clk_i(clk), .arst_n_i(arst_n), .bus_rd_i(rd), .bus_wr_i(wr),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .bus_rdata_oe_o(oe), .rxd_in_valid_i(vld[0]), .rxd_in_ready_o(rdy[0]),
    .rxd_in_data_i(dat), .rxs_in_valid_i(vld[1]), .rxs_in_ready_o(rdy[1]),
    .rxs_in_data_i(dat), .txd_out_valid_o(tvld), .txd_out_ready_i(trdy),
    .txd_out_data_o(tdat), .txs_in_valid_i(vld[2]), .txs_in_ready_o(rdy[2]),
    .txs_in_data_i(dat), .link_up_i(link), .line_err_i(err),
    .word_mode_o(wmode));
  hfpa_mac_model hfpa_mac_model_inst (
    .clk_i(clk), .stall_i(stall), .vld_o(vld), .rdy_i(rdy), .dat_o(dat),
    .tx_vld_i(tvld), .tx_rdy_o(trdy), .tx_dat_i(tdat));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic bad(input string m);
    fails++;
    $display("ERROR %0t %s", $time, m);
  endtask : bad
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_b(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_b
  // answer is registered: oe stands in the cycle after the taking edge
  task automatic rd_b(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    if (oe !== 1'b1) begin
      bad("no read answer");
    end
    d = rdata;
  endtask : rd_b
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_b(a, d);
    chk(d, e);
  endtask : rdc
  task automatic push(input int q, input logic [31:0] d);
    bit ok;
    hfpa_mac_model_inst.push(q, d, ok);
    if (!ok) begin
      bad("push stuck");
      give_verdict();
    end
  endtask : push
  task automatic wait_tx(input int n);
    int i;
    for (i = 0; i < 200 && hfpa_mac_model_inst.txq.size() < n; i++) begin
      @(posedge clk);
    end
    if (hfpa_mac_model_inst.txq.size() < n) begin
      bad("drain timeout");
      give_verdict();
    end
  endtask : wait_tx
  task automatic t_reset;
    rdc(hfpa_pkg::CTRL_OFS, 32'h0010_1000);
    rdc(hfpa_pkg::TXLIM_OFS, 32'h0);
    rdc(hfpa_pkg::STAT_OFS, 32'h0);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
  endtask : t_reset
  task automatic t_rxd;
    int i;
    for (i = 0; i < 8; i++) begin
      push(0, 32'hD000_0000 + i);
    end
    wr_b(hfpa_pkg::RXD_BASE, 32'h0);
    wr_b(hfpa_pkg::STAT_OFS, 32'h0);
    rdc(hfpa_pkg::STAT_OFS, 32'h0000_0008);
    for (i = 0; i < 8; i++) begin
      rdc(8'(4 * i), 32'hD000_0000 + i);
    end
    rdc(hfpa_pkg::STAT_OFS, 32'h0);
  endtask : t_rxd
  task automatic t_sts;
    int k;
    logic [7:0] a;
    for (k = 0; k < 2; k++) begin
      a = k ? hfpa_pkg::TXS_POP : hfpa_pkg::RXS_POP;
      push(k + 1, 32'h5A00_0001);
      push(k + 1, 32'h5A00_0002);
      rdc(8'(a + 8'h04), 32'h5A00_0001);
      rdc(8'(a + 8'h04), 32'h5A00_0001);
      rdc(a, 32'h5A00_0001);
      rdc(hfpa_pkg::STAT_OFS, 32'h1 << (16 + 8 * k));
      rdc(8'(a + 8'h04), 32'h5A00_0002);
      rdc(a, 32'h5A00_0002);
    end
    rdc(hfpa_pkg::STAT_OFS, 32'h0);
  endtask : t_sts
  // far side stalls while the host fills past the programmed limit
  task automatic t_txd;
    int i;
    @(posedge clk);
    stall <= 1'b1;
    wr_b(hfpa_pkg::TXLIM_OFS, 32'h0000_0008);
    for (i = 0; i < 8; i++) begin
      wr_b(8'(8'h20 + 4 * i), 32'hC000_0000 + i);
    end
    wr_b(hfpa_pkg::TXD_BASE, 32'hC000_00FF);
    rdc(hfpa_pkg::STAT_OFS, 32'h0000_0800);
    rdc(8'h3C, 32'h0);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0009);
    wr_b(hfpa_pkg::EVT_OFS, 32'h0000_0001);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
    @(posedge clk);
    stall <= 1'b0;
    wait_tx(8);
    for (i = 0; i < 8; i++) begin
      chk(hfpa_mac_model_inst.txq[i], 32'hC000_0000 + i);
    end
  endtask : t_txd
  task automatic t_evt;
    logic [31:0] d;
    rd_b(hfpa_pkg::RXD_BASE, d);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_000A);
    wr_b(hfpa_pkg::EVT_OFS, 32'h0);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_000A);
    wr_b(hfpa_pkg::EVT_OFS, 32'h0000_0002);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
    rd_b(hfpa_pkg::RXS_POP, d);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_000C);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
    @(posedge clk);
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0018);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
    @(posedge clk);
    link <= 1'b0;
    @(posedge clk);
    link <= 1'b1;
    rdc(hfpa_pkg::EVT_OFS, 32'h0);
    rdc(hfpa_pkg::EVT_OFS, 32'h0000_0008);
  endtask : t_evt
  // soft reset with word mode set, then half-word traffic
  task automatic t_srst;
    logic [31:0] d;
    push(0, 32'h1234_5678);
    wr_b(hfpa_pkg::CTRL_OFS, 32'h0010_0802);
    wr_b(hfpa_pkg::CTRL_OFS, 32'h0010_0803);
    repeat (3) @(posedge clk);
    rdc(hfpa_pkg::CTRL_OFS, 32'h0010_1002);
    chk({31'h0, wmode}, 32'h1);
    rdc(hfpa_pkg::STAT_OFS, 32'h0);
    push(0, 32'hBEEF_CAFE);
    rd_b(8'h02, d);
    chk({16'h0, d[15:0]}, 32'h0000_CAFE);
    rd_b(8'h1E, d);
    chk({16'h0, d[15:0]}, 32'h0000_BEEF);
    rdc(hfpa_pkg::STAT_OFS, 32'h0);
    hfpa_mac_model_inst.txq.delete();
    wr_b(8'h22, 32'h0000_1111);
    wr_b(8'h3E, 32'h0000_2222);
    wait_tx(1);
    chk(hfpa_mac_model_inst.txq[0], 32'h2222_1111);
    wr_b(hfpa_pkg::CTRL_OFS, 32'h0010_1000);
  endtask : t_srst
  initial begin
    #400000;
    bad("run timeout");
    give_verdict();
  end
  // only documented locations are written, never reserved ones
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_rxd();
    t_sts();
    t_txd();
    t_evt();
    t_srst();
    give_verdict();
  end
endmodule : hfpa_tb_top
